// ### bp_cfg.svh
// Register offsets, field positions, reset values and timing counts of the breakpoint block.
`ifndef BP_CFG_SVH
`define BP_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define BP_OFF_CONTROL 12'h000
`define BP_OFF_ADDR_HIGH 12'h004
`define BP_OFF_ADDR_LOW 12'h008
`define BP_OFF_CLOCK_SEL 12'h00C
`define BP_OFF_INT_STATUS 12'h010
`define BP_OFF_INT_MASK 12'h014

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define BP_CTL_HIT_BIT 1
`define BP_CTL_PULSE_BIT 2
`define BP_CTL_ENABLE_BIT 3

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define BP_CLOCK_SEL_RESET 2'h0
`define BP_PULSE_CORE_CLOCKS 8
`define BP_PCLK_MHZ 200
`define BP_CORE_MHZ_12 12
`define BP_CORE_MHZ_24 24
`define BP_CORE_MHZ_48 48

`endif

// ### bp_pkg.sv
// Types shared by the breakpoint block.
`default_nettype none
package bp_pkg;

    // Core clock rate selection.
    typedef enum logic [1:0] {
        CORE_12MHZ = 2'h0,
        CORE_24MHZ = 2'h1,
        CORE_48MHZ = 2'h2
    } core_rate_e;

    // Software controls of the comparator.
    typedef struct packed {
        logic match_enable;
        logic pulse_select;
        logic [15:0] address;
    } bp_setup_s;

endpackage
`default_nettype wire

// ### core_clock_tick.sv
// Divider that makes the core clock enable pulse at 12, 24 or 48 MHz from pclk.
`timescale 1ns/1ps
`default_nettype none
`include "bp_cfg.svh"

module core_clock_tick (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Rate selection.
    input wire logic [1:0] rate,
    // One-cycle enable per core clock.
    output logic tick
);

    // Fractional accumulator: add core rate, wrap at pclk rate, so the mean rate is exact.
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic [7:0] step;
    logic [8:0] sum;
    logic wrap;

    // Step selection; an illegal code falls back to the reset rate.
    assign step = (rate == 2'h1) ? 8'(`BP_CORE_MHZ_24) :
                  (rate == 2'h2) ? 8'(`BP_CORE_MHZ_48) : 8'(`BP_CORE_MHZ_12);
    assign sum = {1'b0, acc_q} + {1'b0, step};
    assign wrap = sum >= 9'(`BP_PCLK_MHZ);
    assign acc_d = wrap ? 8'(sum - 9'(`BP_PCLK_MHZ)) : sum[7:0];
    assign tick = wrap;

    // Accumulator register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
        end
    end

endmodule // core_clock_tick
`default_nettype wire

// ### bp_unit.sv
// Address breakpoint comparator with pin driver and APB register file.
`timescale 1ns/1ps
`default_nettype none
`include "bp_cfg.svh"

module bp_unit (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core address bus, same clock domain.
    input wire logic [15:0] core_address,
    input wire logic core_address_valid,
    // Pin and interrupt.
    output logic breakpoint_out,
    output logic irq
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] bp_address_high_q;
    logic [7:0] bp_address_low_q;
    logic bp_match_enable_q;
    logic bp_pulse_select_q;
    logic hit_q;
    logic [1:0] clock_sel_q;
    logic int_status_q;
    logic int_mask_q;
    logic breakpoint_out_q;
    logic [3:0] pulse_count_q;
    logic match_d_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;

    bp_pkg::bp_setup_s setup;
    logic tick;
    logic access;
    logic wr;
    logic known;
    logic match;
    logic match_rise;
    logic clear_hit;
    logic clear_int;
    logic [31:0] rd_value;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = (a == off);
    endfunction

    // Zero-wait slave: every access completes in its first access cycle.
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign known = is_addr(paddr, `BP_OFF_CONTROL) || is_addr(paddr, `BP_OFF_ADDR_HIGH) ||
                   is_addr(paddr, `BP_OFF_ADDR_LOW) || is_addr(paddr, `BP_OFF_CLOCK_SEL) ||
                   is_addr(paddr, `BP_OFF_INT_STATUS) || is_addr(paddr, `BP_OFF_INT_MASK);
    assign pready = 1'b1;

    // ------------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------------
    assign setup.match_enable = bp_match_enable_q;
    assign setup.pulse_select = bp_pulse_select_q;
    assign setup.address = {bp_address_high_q, bp_address_low_q};
    assign match = setup.match_enable && core_address_valid && (core_address == setup.address);
    // A held address counts once, so a long stall does not restart the pulse endlessly.
    assign match_rise = match && !match_d_q;
    assign clear_hit = wr && is_addr(paddr, `BP_OFF_CONTROL) && pwdata[`BP_CTL_HIT_BIT];
    assign clear_int = wr && is_addr(paddr, `BP_OFF_INT_STATUS) && pwdata[0];

    core_clock_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .rate(clock_sel_q),
        .tick(tick)
    );

    // Read mux.
    assign rd_value =
        is_addr(paddr, `BP_OFF_CONTROL) ? 32'({bp_match_enable_q, bp_pulse_select_q, hit_q, 1'b0}) :
        is_addr(paddr, `BP_OFF_ADDR_HIGH) ? {24'h000000, bp_address_high_q} :
        is_addr(paddr, `BP_OFF_ADDR_LOW) ? {24'h000000, bp_address_low_q} :
        is_addr(paddr, `BP_OFF_CLOCK_SEL) ? {30'h00000000, clock_sel_q} :
        is_addr(paddr, `BP_OFF_INT_STATUS) ? {31'h00000000, int_status_q} :
        is_addr(paddr, `BP_OFF_INT_MASK) ? {31'h00000000, int_mask_q} : 32'h00000000;

    // ------------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_address_high_q <= 8'h00;
            bp_address_low_q <= 8'h00;
            bp_match_enable_q <= 1'b0;
            bp_pulse_select_q <= 1'b0;
            int_mask_q <= 1'b0;
            clock_sel_q <= `BP_CLOCK_SEL_RESET;
        end else if (wr) begin
            if (is_addr(paddr, `BP_OFF_ADDR_HIGH)) begin
                bp_address_high_q <= pwdata[7:0];
            end
            if (is_addr(paddr, `BP_OFF_ADDR_LOW)) begin
                bp_address_low_q <= pwdata[7:0];
            end
            if (is_addr(paddr, `BP_OFF_CONTROL)) begin
                bp_match_enable_q <= pwdata[`BP_CTL_ENABLE_BIT];
                bp_pulse_select_q <= pwdata[`BP_CTL_PULSE_BIT];
            end
            // Rate select; the unused code 3 is refused and the rate kept.
            if (is_addr(paddr, `BP_OFF_CLOCK_SEL) && pwdata[1:0] != 2'h3) begin
                clock_sel_q <= pwdata[1:0];
            end
            if (is_addr(paddr, `BP_OFF_INT_MASK)) begin
                int_mask_q <= pwdata[0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Hit flag and interrupt status: a new hit wins over a clear.
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_d_q <= 1'b0;
            hit_q <= 1'b0;
            int_status_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            match_d_q <= match;
            hit_q <= match_rise || (hit_q && !clear_hit);
            int_status_q <= match_rise || (int_status_q && !clear_int);
            irq_q <= int_mask_q && (match_rise || (int_status_q && !clear_int));
        end
    end

    // ------------------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breakpoint_out_q <= 1'b0;
            pulse_count_q <= 4'h0;
        end else if (match_rise) begin
            breakpoint_out_q <= 1'b1;
            pulse_count_q <= 4'(`BP_PULSE_CORE_CLOCKS);
        end else if (bp_pulse_select_q) begin
            if (tick && pulse_count_q != 4'h0) begin
                pulse_count_q <= pulse_count_q - 4'h1;
                breakpoint_out_q <= (pulse_count_q != 4'h1);
            end else if (pulse_count_q == 4'h0) begin
                breakpoint_out_q <= 1'b0;
            end
        end else begin
            breakpoint_out_q <= hit_q && !clear_hit;
            pulse_count_q <= 4'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= (psel && !penable && !pwrite && known) ? rd_value : 32'h00000000;
            pslverr_q <= psel && !penable && !known;
        end
    end

    // Both flops are loaded only in a setup cycle and cleared at every other edge,
    // so they stand exactly in the access cycle and can leave the block directly.
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign breakpoint_out = breakpoint_out_q;
    assign irq = irq_q;

endmodule // bp_unit
`default_nettype wire

// ### bp_probe.sv
// Pin monitor standing in for the external debug equipment.
`timescale 1ns/1ps
`default_nettype none
module bp_probe (
    // Clock and watched pin.
    input wire logic pclk,
    input wire logic breakpoint_out,
    // Last high width in pclk cycles, and count of rising edges.
    output int width,
    output int rises
);
    int run = 0;
    logic seen = 1'b0;
    // The equipment only listens, so it never loads or drives the pin.
    always @(posedge pclk) begin
        if (breakpoint_out && !seen) rises <= rises + 1;
        if (!breakpoint_out && seen) width <= run;
        run <= breakpoint_out ? run + 1 : 0;
        seen <= breakpoint_out;
    end
endmodule // bp_probe
`default_nettype wire

// ### bp_unit_asserts.sv
// Concurrent checks on the ports of the breakpoint block.
`timescale 1ns/1ps
`default_nettype none
module bp_unit_asserts (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core bus, pin and interrupt.
    input wire logic [15:0] core_address,
    input wire logic core_address_valid,
    input wire logic breakpoint_out,
    input wire logic irq
);
    logic [7:0] hi_cnt_q;
    wire acc_w = psel && penable && pwrite;
    // Saturating count of high cycles, so a short pulse without a clear write is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_q <= 8'h00;
        else if (!breakpoint_out) hi_cnt_q <= 8'h00;
        else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pin and interrupt behaviour against their causes.
    property p_rise_valid; $rose(breakpoint_out) |-> $past(core_address_valid); endproperty
    a_rise_valid: assert property (p_rise_valid) else $error("pin rose without a valid address");
    property p_fall_cause; $fell(breakpoint_out) |-> hi_cnt_q >= 8'h1C || $past(acc_w) || $past(acc_w, 2); endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("pin fell too early");
    property p_irq_fall; $fell(irq) |-> $past(acc_w) || $past(acc_w, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
    property p_rst_low; disable iff (1'b0) !presetn |-> !breakpoint_out && !irq; endproperty
    a_rst_low: assert property (p_rst_low) else $error("output high in reset");
    // Bus answers stay inside the access phase.
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_rdata_idle; !(psel && penable) |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
endmodule // bp_unit_asserts
bind bp_unit bp_unit_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_address, .core_address_valid, .breakpoint_out, .irq);
`default_nettype wire

// ### address_breakpoint_output_tb.sv
// Self-checking bench of the address breakpoint block.
`timescale 1ns/1ps
`default_nettype none
`include "bp_cfg.svh"
module address_breakpoint_output_tb;
    localparam logic [11:0] CTL = `BP_OFF_CONTROL;
    localparam logic [11:0] STA = `BP_OFF_INT_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic err = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, breakpoint_out, irq;
    logic [15:0] core_address = 16'h0000;
    logic core_address_valid = 1'b0;
    int width, rises, error_cnt = 0, checks_done = 0;
    // A 5 ns period gives the 200 MHz bus clock.
    always #2.5 pclk = ~pclk;
    bp_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .core_address, .core_address_valid, .breakpoint_out, .irq);
    bp_probe probe (.pclk, .breakpoint_out, .width, .rises);
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
        end
    endtask
    // One APB transfer; the pause after it lets slower side effects land before checks.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // One qualified core address, then an unrelated one so the match edge is fresh.
    task automatic hit(input logic [15:0] a);
        @(posedge pclk);
        core_address <= a;
        core_address_valid <= 1'b1;
        @(posedge pclk);
        core_address_valid <= 1'b0;
        core_address <= ~a;
        repeat (3) @(posedge pclk);
    endtask
    task automatic t_reset;
        chk(breakpoint_out, 32'h0);
        chk(irq, 32'h0);
        apb(1'b0, `BP_OFF_CLOCK_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `BP_OFF_CLOCK_SEL, 32'h3);
        apb(1'b0, `BP_OFF_CLOCK_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_hold;
        apb(1'b1, `BP_OFF_ADDR_HIGH, 32'h12);
        apb(1'b1, `BP_OFF_ADDR_LOW, 32'h34);
        apb(1'b1, CTL, 32'h8);
        hit(16'h1235);
        hit(16'h0234);
        chk(breakpoint_out, 32'h0);
        hit(16'h1234);
        chk(breakpoint_out, 32'h1);
        apb(1'b1, CTL, 32'h8);
        chk(breakpoint_out, 32'h1);
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'hA);
        apb(1'b1, CTL, 32'hA);
        chk(breakpoint_out, 32'h0);
        apb(1'b1, CTL, 32'h0);
        hit(16'h1234);
        chk(breakpoint_out, 32'h0);
        $display("test hold done");
    endtask
    task automatic t_pulse;
        int mhz[3] = '{`BP_CORE_MHZ_12, `BP_CORE_MHZ_24, `BP_CORE_MHZ_48};
        int r0;
        r0 = rises;
        apb(1'b1, CTL, 32'hC);
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, `BP_OFF_CLOCK_SEL, 32'(r));
            hit(16'h1234);
            chk(breakpoint_out, 32'h1);
            for (int n = 0; n < 400 && breakpoint_out !== 1'b0; n++) @(posedge pclk);
            @(posedge pclk);
            // First core tick may come up to one core period early, hence seven periods at least.
            chk_rng(width, 7 * `BP_PCLK_MHZ / mhz[r], 8 * `BP_PCLK_MHZ / mhz[r] + 2);
        end
        chk(32'(rises - r0), 32'h3);
        $display("test pulse done");
    endtask
    task automatic t_irq;
        apb(1'b1, CTL, 32'hA);
        apb(1'b1, STA, 32'h1);
        apb(1'b1, `BP_OFF_INT_MASK, 32'h1);
        chk(irq, 32'h0);
        hit(16'h1234);
        chk(irq, 32'h1);
        apb(1'b1, STA, 32'h0);
        chk(irq, 32'h1);
        apb(1'b1, STA, 32'h1);
        chk(irq, 32'h0);
        apb(1'b1, `BP_OFF_INT_MASK, 32'h0);
        hit(16'h1234);
        chk(irq, 32'h0);
        apb(1'b0, STA, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        $display("test irq done");
    endtask
    // Main sequence after six cycles of reset; the falling reset edge at time zero clears
    // every flop in bp_unit before the first clock edge, so no check ever sees an unknown output.
    initial begin
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_hold;
        t_pulse;
        t_irq;
        stop_test;
    end
    // Watchdog well beyond the expected run of about 400 cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        stop_test;
    end
endmodule // address_breakpoint_output_tb
`default_nettype wire
